// ### verilog/dtw_pkg.sv
package dtw_pkg;

  localparam logic [6:0] BCAST_ADDR = 7'h48;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [4:0] ADDR_HI_FLOAT = 5'h03;
  localparam logic [4:0] ADDR_HI_GND = 5'h02;
  localparam logic [4:0] ADDR_HI_SUPPLY = 5'h13;
  localparam logic [1:0] ADDR_LO_FLOAT = 2'h0;
  localparam logic [1:0] ADDR_LO_GND = 2'h1;
  localparam logic [1:0] ADDR_LO_SUPPLY = 2'h2;
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_FLOAT = 2'h1;
  localparam logic [1:0] LVL_SUPPLY = 2'h2;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic [1:0] zero;
    logic [1:0] pd;
    logic [11:0] code;
  } dtw_word_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_WRX = 3'b011,
    ST_WACK = 3'b100,
    ST_RDX = 3'b101,
    ST_RACK = 3'b110
  } dtw_state_e;

endpackage

// ### verilog/dtw_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module dtw_fifo import dtw_pkg::*; #(
  parameter int WIDTH = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = cnt_q != CW'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? AW'(wp_q + AW'(1)) : wp_q;
    rp_d = pop ? AW'(rp_q + AW'(1)) : rp_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ### verilog/dtw_slave.sv
`timescale 1ns/10ps
`default_nettype none
module dtw_slave import dtw_pkg::*; #(
  parameter bit TWO_STRAPS = 1'b1,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address straps, three-level codes from the pin sensors
  input wire logic [1:0] addr_strap_low,
  input wire logic [1:0] addr_strap_high,
  output logic strap_sense_en,
  output logic addr_locked,
  // converter side
  input wire logic dac_load_ready,
  output logic [11:0] analog_output_code,
  output logic powerdown_sel_high,
  output logic powerdown_sel_low,
  output logic output_active,
  output logic hs_mode
);

  // ---------------- pin synchronisers
  logic [2:0] scl_sq, sda_sq;
  logic [2:0][3:0] strap_sq;
  logic scl_fq, scl_d, sda_fq, sda_d;
  logic [3:0] strap_fq, strap_d;
  logic rise, fall, start, stop;

  always_comb begin
    // a change counts only once stages two and three agree
    scl_d = (scl_sq[2] == scl_sq[1]) ? scl_sq[2] : scl_fq;
    sda_d = (sda_sq[2] == sda_sq[1]) ? sda_sq[2] : sda_fq;
    strap_d = (strap_sq[2] == strap_sq[1]) ? strap_sq[2] : strap_fq;
    rise = !scl_fq && scl_d;
    fall = scl_fq && !scl_d;
    start = scl_fq && scl_d && sda_fq && !sda_d;
    stop = scl_fq && scl_d && !sda_fq && sda_d;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_sq <= 3'h7;
      sda_sq <= 3'h7;
      strap_sq <= '0;
      scl_fq <= 1'b1;
      sda_fq <= 1'b1;
      strap_fq <= '0;
    end else begin
      scl_sq <= {scl_sq[1:0], scl_in};
      sda_sq <= {sda_sq[1:0], sda_in};
      strap_sq <= {strap_sq[1:0], {addr_strap_high, addr_strap_low}};
      scl_fq <= scl_d;
      sda_fq <= sda_d;
      strap_fq <= strap_d;
    end
  end

  // ---------------- strap address decode and lock
  function automatic logic [6:0] strap_addr(input logic [1:0] hi, input logic [1:0] lo);
    logic [4:0] top;
    logic [1:0] low;
    top = ADDR_HI_FLOAT;
    low = ADDR_LO_FLOAT;
    case (hi)
      LVL_GND: top = ADDR_HI_GND;
      LVL_SUPPLY: top = ADDR_HI_SUPPLY;
      default: top = ADDR_HI_FLOAT;
    endcase
    case (lo)
      LVL_GND: low = ADDR_LO_GND;
      LVL_SUPPLY: low = ADDR_LO_SUPPLY;
      default: low = ADDR_LO_FLOAT;
    endcase
    return {top, low};
  endfunction

  logic [6:0] own_q, own_d;
  logic lock_q, lock_d;
  logic sense_q;

  always_comb begin
    own_d = own_q;
    // single-strap variant behaves as if the upper strap floats
    if (!lock_q) begin
      own_d = strap_addr(TWO_STRAPS ? strap_fq[3:2] : LVL_FLOAT, strap_fq[1:0]);
    end
  end

  // ---------------- bus engine
  dtw_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, up_q, up_d;
  logic hi_q, hi_d, ack_q, ack_d, oe_q, oe_d, hs_q, hs_d;
  logic own_hit, bc_hit, push, f_in_ready;
  dtw_word_s word_q, word_d, rd_word, f_out;
  logic f_out_valid;

  assign rd_word = word_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    up_d = up_q;
    hi_d = hi_q;
    ack_d = ack_q;
    oe_d = oe_q;
    hs_d = hs_q;
    lock_d = lock_q;
    push = 1'b0;
    own_hit = sh_q[7:1] == own_q;
    bc_hit = sh_q[7:1] == BCAST_ADDR;
    if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
      hs_d = 1'b0;
    end else if (start) begin
      // repeated start keeps the speed mode
      st_d = ST_ADDR;
      cnt_d = '0;
      oe_d = 1'b0;
    end else if (rise) begin
      case (st_q)
        ST_ADDR, ST_WRX: begin
          sh_d = {sh_q[6:0], sda_fq};
          cnt_d = 4'(cnt_q + 4'h1);
        end
        ST_RDX: cnt_d = 4'(cnt_q + 4'h1);
        ST_WACK: push = !hi_q && f_in_ready;
        ST_RACK: ack_d = !sda_fq;
        default: ;
      endcase
    end else if (fall) begin
      case (st_q)
        ST_ADDR: begin
          if (cnt_q == BYTE_BITS) begin
            if (own_hit || bc_hit) begin
              st_d = ST_AACK;
              oe_d = 1'b1;
              lock_d = lock_q || own_hit;
            end else begin
              st_d = ST_IDLE;
              if (sh_q[7:3] == HS_CODE_TOP) begin
                hs_d = 1'b1;
              end
            end
          end
        end
        ST_AACK: begin
          cnt_d = '0;
          hi_d = 1'b1;
          if (sh_q[0]) begin
            st_d = ST_RDX;
            sh_d = rd_word[15:8];
            oe_d = !rd_word[15];
          end else begin
            st_d = ST_WRX;
            oe_d = 1'b0;
          end
        end
        ST_WRX: begin
          if (cnt_q == BYTE_BITS) begin
            // a full queue refuses the lower byte with a nack
            if (hi_q || f_in_ready) begin
              st_d = ST_WACK;
              oe_d = 1'b1;
              if (hi_q) begin
                up_d = sh_q;
              end
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        ST_WACK: begin
          st_d = ST_WRX;
          oe_d = 1'b0;
          cnt_d = '0;
          hi_d = !hi_q;
        end
        ST_RDX: begin
          if (cnt_q == BYTE_BITS) begin
            st_d = ST_RACK;
            oe_d = 1'b0;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            oe_d = !sh_q[6];
          end
        end
        ST_RACK: begin
          if (ack_q) begin
            st_d = ST_RDX;
            cnt_d = '0;
            hi_d = !hi_q;
            sh_d = hi_q ? rd_word[7:0] : rd_word[15:8];
            oe_d = hi_q ? !rd_word[7] : !rd_word[15];
          end else begin
            st_d = ST_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      up_q <= '0;
      hi_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      hs_q <= 1'b0;
      lock_q <= 1'b0;
      own_q <= {ADDR_HI_FLOAT, ADDR_LO_FLOAT};
      sense_q <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      up_q <= up_d;
      hi_q <= hi_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      hs_q <= hs_d;
      lock_q <= lock_d;
      own_q <= own_d;
      sense_q <= !lock_d;
    end
  end

  // ---------------- word queue toward the converter
  dtw_fifo #(
    .WIDTH(16),
    .DEPTH(DEPTH)
  ) i_dtw_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data({up_q, sh_q}),
    .out_valid(f_out_valid),
    .out_ready(dac_load_ready),
    .out_data(f_out)
  );

  // ---------------- output-code register
  logic active_q, active_d;

  always_comb begin
    word_d = word_q;
    if (f_out_valid && dac_load_ready) begin
      word_d = f_out;
      word_d.zero = 2'h0;
    end
    active_d = word_d.pd == PD_NORMAL;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      word_q <= WORD_RESET;
      active_q <= 1'b1;
    end else begin
      word_q <= word_d;
      active_q <= active_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;
  assign strap_sense_en = sense_q;
  assign addr_locked = lock_q;
  assign analog_output_code = word_q.code;
  assign powerdown_sel_high = word_q.pd[1];
  assign powerdown_sel_low = word_q.pd[0];
  assign output_active = active_q;
  assign hs_mode = hs_q;

  // ---------------- checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  addr_lock_a: assert property (lock_q |=> lock_q && $stable(own_q))
    else $error("address changed after lock");
  sense_off_a: assert property ($rose(lock_q) |-> !sense_q ##1 !sense_q)
    else $error("strap sensing still on after lock");
  reset_zero_a: assert property ($fell(srst) |-> word_q == WORD_RESET)
    else $error("word not cleared by reset");
  drive_only_a: assert property (oe_q |-> st_q inside {ST_AACK, ST_WACK, ST_RDX})
    else $error("data line driven outside ack or read");
  addr_ack_a: assert property ((fall && st_q == ST_ADDR && cnt_q == BYTE_BITS && !start && !stop
    && (own_hit || bc_hit)) |=> st_q == ST_AACK && oe_q)
    else $error("matching address not acknowledged");
  hs_nack_a: assert property ((fall && st_q == ST_ADDR && cnt_q == BYTE_BITS && !stop
    && sh_q[7:3] == HS_CODE_TOP) |=> st_q == ST_IDLE && !oe_q && hs_q)
    else $error("high-speed code mishandled");
  word_apply_a: assert property ((push && !f_out_valid) ##1 dac_load_ready
    |=> word_q == {2'h0, $past(up_q[5:0], 2), $past(sh_q, 2)})
    else $error("written word not applied");
  pd_active_a: assert property (output_active == (word_q.pd == PD_NORMAL))
    else $error("power-down state disagrees with mode bits");
  read_load_a: assert property ((st_q == ST_AACK && fall && !start && !stop && sh_q[0])
    |=> st_q == ST_RDX && sh_q == {2'h0, $past(word_q[13:8])})
    else $error("read did not load stored upper byte");

endmodule
`default_nettype wire

// ### bench/dtw_master.sv
`timescale 1ns/10ps
`default_nettype none
module dtw_master (
  // clock
  input wire logic sys_clk,
  // bus
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // quarter of a 160 ns bus period
  task automatic q;
    repeat (4) @(negedge sys_clk);
  endtask
  // also serves as repeated start
  task automatic start;
    sda_pull = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop;
    sda_pull = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_pull = 1'b0;
    q();
  endtask
  task automatic bit_io(input logic b, output logic s);
    sda_pull = ~b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  // lower byte of a single-word read ends with a nack, data line left high
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, s);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_dac_twowire_slave_register.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_dac_twowire_slave_register import dtw_pkg::*;;
  typedef struct packed {
    logic [15:0] wr;
    logic [15:0] rd;
    logic act;
  } dtw_row_s;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] strap_lo = LVL_GND;
  logic [1:0] strap_hi = LVL_FLOAT;
  logic load_rdy = 1'b1;
  wire logic scl, sda, sda_pull, sda_oe, sda_out, sense_en, locked, pd_hi, pd_lo, active, hs;
  wire logic [11:0] code;
  int errors = 0;
  int n_tests = 0;
  logic ack, k, all_k;
  logic [15:0] w;
  dtw_row_s rows [5] = '{
    '{16'h0abc, 16'h0abc, 1'b1}, '{16'h1fff, 16'h1fff, 1'b0}, '{16'h2000, 16'h2000, 1'b0},
    '{16'hf5a5, 16'h35a5, 1'b0}, '{16'h0001, 16'h0001, 1'b1}};
  always #5 sys_clk = ~sys_clk;
  // pulled-up bus, either party may pull low
  assign sda = (sda_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  dtw_master i_dtw_master (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
  dtw_slave #(.TWO_STRAPS(1'b1), .DEPTH(32)) i_dtw_slave (
    .sys_clk(sys_clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_low(strap_lo), .addr_strap_high(strap_hi), .strap_sense_en(sense_en),
    .addr_locked(locked), .dac_load_ready(load_rdy), .analog_output_code(code),
    .powerdown_sel_high(pd_hi), .powerdown_sel_low(pd_lo), .output_active(active), .hs_mode(hs));
  task automatic probe(input logic [6:0] a, output logic ok);
    i_dtw_master.start();
    i_dtw_master.wr_byte({a, 1'b0}, ok);
    i_dtw_master.stop();
  endtask
  task automatic wr_word(input logic [6:0] a, input logic [15:0] d, output logic ok);
    logic k1, k2, k3;
    i_dtw_master.start();
    i_dtw_master.wr_byte({a, 1'b0}, k1);
    i_dtw_master.wr_byte(d[15:8], k2);
    i_dtw_master.wr_byte(d[7:0], k3);
    i_dtw_master.stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
    logic k1;
    i_dtw_master.start();
    i_dtw_master.wr_byte({a, 1'b1}, k1);
    `CHK(k1, 1'b1)
    i_dtw_master.rd_byte(1'b1, d[15:8]);
    i_dtw_master.rd_byte(1'b0, d[7:0]);
    i_dtw_master.stop();
  endtask
  task automatic tdone(input string name);
    $display("test %s done", name);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 16k cycles expected
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    results();
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK(code, 12'h000)
    `CHK({pd_hi, pd_lo, active, sense_en, locked, sda_oe}, 6'b001100)
    tdone("reset");
    // broadcast must not lock the straps
    wr_word(BCAST_ADDR, 16'h0123, ack);
    `CHK(ack, 1'b1)
    `CHK(code, 12'h123)
    `CHK({sense_en, locked}, 2'b10)
    probe(7'h0c, ack);
    `CHK(ack, 1'b0)
    tdone("broadcast");
    for (int i = 0; i < 5; i++) begin
      wr_word(7'h0d, rows[i].wr, ack);
      `CHK(ack, 1'b1)
      `CHK(code, rows[i].rd[11:0])
      `CHK({pd_hi, pd_lo}, rows[i].rd[13:12])
      `CHK(active, rows[i].act)
      rd_word(7'h0d, w);
      `CHK(w, rows[i].rd)
    end
    tdone("rows");
    `CHK({sense_en, locked}, 2'b01)
    strap_hi = LVL_SUPPLY;
    probe(7'h0d, ack);
    `CHK(ack, 1'b1)
    probe(7'h4d, ack);
    `CHK(ack, 1'b0)
    // no other bus party is ever placed on the reserved pair address
    probe(7'h46, ack);
    `CHK(ack, 1'b0)
    tdone("lock");
    i_dtw_master.start();
    i_dtw_master.wr_byte(8'h08, ack);
    `CHK(ack, 1'b0)
    i_dtw_master.start();
    `CHK(hs, 1'b1)
    i_dtw_master.wr_byte({7'h0d, 1'b0}, ack);
    `CHK(ack, 1'b1)
    i_dtw_master.stop();
    `CHK(hs, 1'b0)
    tdone("high speed");
    // converter stalls so the queue fills
    load_rdy = 1'b0;
    all_k = 1'b1;
    i_dtw_master.start();
    i_dtw_master.wr_byte({7'h0d, 1'b0}, k);
    for (int i = 0; i < 33; i++) begin
      i_dtw_master.wr_byte(8'h01, k);
      all_k &= k;
      i_dtw_master.wr_byte(i[7:0], k);
      if (i < 32) begin
        all_k &= k;
      end
    end
    i_dtw_master.stop();
    `CHK(all_k, 1'b1)
    `CHK(k, 1'b0)
    `CHK(code, 12'h001)
    load_rdy = 1'b1;
    repeat (40) @(negedge sys_clk);
    `CHK(code, 12'h11f)
    tdone("queue");
    // mid-run reset stands for a power cycle: word cleared, lock dropped
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    `CHK(code, 12'h000)
    `CHK({pd_hi, pd_lo, active, sense_en, locked, sda_oe}, 6'b001100)
    repeat (4) @(negedge sys_clk);
    probe(7'h0d, ack);
    `CHK(ack, 1'b0)
    probe(7'h4d, ack);
    `CHK(ack, 1'b1)
    `CHK({sense_en, locked}, 2'b01)
    tdone("power cycle");
    results();
  end
endmodule
`default_nettype wire
